//--- counter_channel.sv
// One 32-bit counter with pulse, gate, direction and encoder decoding
`timescale 1ns/1ps
`include "fic_defs.svh"
module counter_channel
  import fic_pkg::*;
#(
  parameter int CW = 32
)
(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          a_i,
  input  wire logic          b_i,
  input  wire cnt_func_t     func_i,
  input  wire logic          dir_down_i,
  input  wire logic          periodic_i,
  input  wire logic [CW-1:0] limit_i,
  input  wire logic [CW-1:0] preset_i,
  input  wire logic          load_i,
  output logic      [CW-1:0] count_o,
  output logic               hit_o
);
  logic          a_q;
  logic          b_q;
  logic          a_rise;
  logic          a_fall;
  logic          b_rise;
  logic          b_fall;
  logic          inc;
  logic          dec;
  logic [CW-1:0] next_val;

  // Edges from the already synchronised levels only
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_q <= a_i;
      b_q <= b_i;
    end
  end

  assign a_rise = a_i & ~a_q;
  assign a_fall = ~a_i & a_q;
  assign b_rise = b_i & ~b_q;
  assign b_fall = ~b_i & b_q;

  always_comb
  begin
    inc = 1'b0;
    dec = 1'b0;
    case (func_i)
      FN_PULSE:
      begin
        inc = a_rise & ~dir_down_i; // [RULE4]
        dec = a_rise & dir_down_i; // [RULE4]
      end
      FN_PULSE_DIR:
      begin
        inc = a_rise & (dir_down_i ? b_i : ~b_i); // [RULE5] [RULE6] [RULE7]
        dec = a_rise & (dir_down_i ? ~b_i : b_i); // [RULE5] [RULE6] [RULE7]
      end
      FN_PULSE_GATE:
      begin
        inc = a_rise & b_i & ~dir_down_i; // [RULE8]
        dec = a_rise & b_i & dir_down_i; // [RULE8]
      end
      FN_ENC_SINGLE:
      begin
        inc = a_fall & b_i; // [RULE16]
        dec = a_rise & b_i; // [RULE17]
      end
      FN_ENC_DOUBLE:
      begin
        inc = (a_rise & ~b_i) | (a_fall & b_i); // [RULE18]
        dec = (a_rise & b_i) | (a_fall & ~b_i); // [RULE19]
      end
      FN_ENC_QUAD:
      begin
        inc = (b_rise & a_i) | (b_fall & ~a_i) | (a_rise & ~b_i) | (a_fall & b_i); // [RULE20]
        dec = (b_rise & ~a_i) | (b_fall & a_i) | (a_rise & b_i) | (a_fall & ~b_i); // [RULE21]
      end
      default:
      begin
        inc = 1'b0;
        dec = 1'b0;
      end
    endcase
  end

  // Natural wrap of the full-width sum
  assign next_val = inc ? count_o + 1'b1 : count_o - 1'b1; // [RULE9]

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      count_o <= `COUNT_RST;
      hit_o   <= 1'b0;
    end
    else
    begin
      hit_o <= 1'b0;
      if (load_i)
        count_o <= preset_i; // [RULE12]
      else if (inc != dec)
      begin
        if (periodic_i && next_val == limit_i) // [RULE13]
        begin
          count_o <= preset_i; // [RULE10]
          hit_o   <= 1'b1; // [RULE10]
        end
        else
          count_o <= next_val; // [RULE9]
      end
    end
  end
endmodule

//--- fast_input_counter.sv
// Fast input counter block with AHB-Lite register slave and process image
`timescale 1ns/1ps
`include "fic_defs.svh"
// Operation
// [RULE1] Counters mirrored to 16-byte image, movable base
// [RULE2] All counter functions off after reset
// [RULE3] Four counters on the first four inputs
// [RULE4] Pulse mode: one input, step per pulse
// [RULE5] Pulse with direction: two inputs, two counters
// [RULE6] Polarity up: low counts up, high down
// [RULE7] Polarity down: high counts up, low down
// [RULE8] Gate mode: count only while gate high
// [RULE9] Free counting wraps at 32 bits
// [RULE10] Limit reached: alarm, reload, keep counting
// [RULE11] Alarm as process or process plus diagnostics
// [RULE12] Preset value loadable while running
// [RULE13] Periodic compares with limit; continuous does not
// [RULE14] Source keeps below rated pulse rate
// [RULE15] Lower source rate with pulse width output
// [RULE16] Single encoder: A falling, B high increments
// [RULE17] Single encoder: A rising, B high decrements
// [RULE18] Double encoder increment edge combinations
// [RULE19] Double encoder decrement edge combinations
// [RULE20] Quadruple encoder increment edge combinations
// [RULE21] Quadruple encoder decrement edge combinations
// [RULE22] Same input delay for all alarm inputs
// [RULE23] Inputs pass two flip-flops before edge detection
module fast_input_counter
  import fic_pkg::*;
#(
  parameter int NCNT = 4,
  parameter int CW   = 32,
  parameter int AW   = 8
)
(
  input  wire logic               CLOCK_I,
  input  wire logic               RST_N_I,
  input  wire logic               HSEL_I,
  input  wire logic [AW-1:0]      HADDR_I,
  input  wire logic [1:0]         HTRANS_I,
  input  wire logic               HWRITE_I,
  input  wire logic [2:0]         HSIZE_I,
  input  wire logic [31:0]        HWDATA_I,
  input  wire logic               HREADY_I,
  output logic      [31:0]        HRDATA_O,
  output logic                    HREADYOUT_O,
  output logic                    HRESP_O,
  input  wire logic [NCNT-1:0]    DIN_I,
  output logic      [NCNT*CW-1:0] COUNT_IMAGE_O,
  output logic      [9:0]         IMAGE_BASE_O,
  output logic      [NCNT-1:0]    PROC_ALARM_O,
  output logic      [NCNT-1:0]    DIAG_ALARM_O
);
  logic [NCNT-1:0] din_s1_q;
  logic [NCNT-1:0] din_s2_q;
  logic            wr_pend_q;
  logic [AW-1:0]   wr_addr_q;
  logic            addr_ok;
  logic            rd_take;
  logic [31:0]     rdata_d;
  logic [7:0]      ctrl_q   [NCNT];
  logic [CW-1:0]   limit_q  [NCNT];
  logic [CW-1:0]   preset_q [NCNT];
  logic [CW-1:0]   count    [NCNT];
  logic [NCNT-1:0] hit;
  logic [NCNT-1:0] alm_ev;
  logic [NCNT-1:0] load_q;
  logic [NCNT-1:0] alarm_q;
  logic [9:0]      img_base_q;
  logic [3:0]      wr_grp;
  logic [1:0]      wr_idx;
  cnt_func_t       func_eff [NCNT];
  logic            wr_ctrl;
  logic            wr_limit;
  logic            wr_preset;
  logic            wr_base;
  logic            wr_load;
  logic            wr_clear;
  logic [NCNT-1:0] dir_down;
  logic [NCNT-1:0] periodic;
  logic [NCNT-1:0] alm_en;
  logic [NCNT-1:0] diag_sel;

  // Two-stage synchroniser for every counter input
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      din_s1_q <= '0;
      din_s2_q <= '0;
    end
    else
    begin
      din_s1_q <= DIN_I; // [RULE23]
      din_s2_q <= din_s1_q; // [RULE23]
    end
  end

  // AHB-Lite address phase capture
  assign addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign rd_take = addr_ok & ~HWRITE_I;
  assign wr_grp  = wr_addr_q[7:4];
  assign wr_idx  = wr_addr_q[3:2];

  // A write is pending for exactly the data phase after its address phase
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      wr_pend_q <= 1'b0;
    else
      wr_pend_q <= addr_ok & HWRITE_I;
  end

  // Address held for the data phase, where the write data arrives
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      wr_addr_q <= '0;
    else if (addr_ok)
      wr_addr_q <= HADDR_I;
  end

  // Data-phase write strobes, one per register or group
  always_comb
  begin
    wr_ctrl   = wr_pend_q & (wr_grp == `GRP_CTRL);
    wr_limit  = wr_pend_q & (wr_grp == `GRP_LIMIT);
    wr_preset = wr_pend_q & (wr_grp == `GRP_PRESET);
    wr_base   = wr_pend_q & (wr_addr_q[7:0] == `OFS_IMG_BASE);
    wr_load   = wr_pend_q & (wr_addr_q[7:0] == `OFS_LOAD);
    wr_clear  = wr_pend_q & (wr_addr_q[7:0] == `OFS_ALARM);
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // Read data register, loaded when a read is taken and held until the next
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      HRDATA_O <= 32'h0000_0000;
    else if (rd_take)
      HRDATA_O <= rdata_d;
  end

  // Read multiplexer, unmapped words read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (HADDR_I[7:4])
      `GRP_CTRL:   rdata_d = {24'h000000, ctrl_q[HADDR_I[3:2]]};
      `GRP_LIMIT:  rdata_d = limit_q[HADDR_I[3:2]];
      `GRP_PRESET: rdata_d = preset_q[HADDR_I[3:2]];
      `GRP_COUNT:  rdata_d = count[HADDR_I[3:2]];
      `GRP_MISC:
      begin
        if (HADDR_I[7:0] == `OFS_IMG_BASE)
          rdata_d = {22'h000000, img_base_q};
        else if (HADDR_I[7:0] == `OFS_ALARM)
          rdata_d = {28'h0000000, alarm_q};
        else
          rdata_d = 32'h0000_0000;
      end
      default:     rdata_d = 32'h0000_0000;
    endcase
  end

  // Channel modes; every counter stays off until software sets a mode
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < NCNT; i++)
        ctrl_q[i] <= `CTRL_RST; // [RULE2]
    end
    else if (wr_ctrl)
      ctrl_q[wr_idx] <= HWDATA_I[7:0];
  end

  // Channel limits
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < NCNT; i++)
        limit_q[i] <= `LIMIT_RST;
    end
    else if (wr_limit)
      limit_q[wr_idx] <= HWDATA_I;
  end

  // Channel presets, used on a limit hit and on a load strobe
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < NCNT; i++)
        preset_q[i] <= `PRESET_RST;
    end
    else if (wr_preset)
      preset_q[wr_idx] <= HWDATA_I;
  end

  // Image base, values above the top are ignored
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      img_base_q <= `IMG_BASE_RST; // [RULE1]
    else if (wr_base
             && HWDATA_I[31:10] == 22'h000000
             && HWDATA_I[9:0] <= `IMG_BASE_MAX) // [RULE1]
      img_base_q <= HWDATA_I[9:0];
  end

  // Preset load strobe, one cycle per written bit
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      load_q <= '0;
    else if (wr_load)
      load_q <= HWDATA_I[NCNT-1:0]; // [RULE12]
    else
      load_q <= '0;
  end

  // Effective function: two-input modes only on counters 0 and 2
  always_comb
  begin
    for (int i = 0; i < NCNT; i++)
    begin
      func_eff[i] = cnt_func_t'(ctrl_q[i][`CTRL_FUNC_LSB +: `CTRL_FUNC_W]);
      if (i % 2 == 1)
      begin
        if (func_eff[i] != FN_PULSE)
          func_eff[i] = FN_OFF; // [RULE5]
        if (cnt_func_t'(ctrl_q[i-1][`CTRL_FUNC_LSB +: `CTRL_FUNC_W]) inside
            {FN_PULSE_DIR, FN_ENC_SINGLE, FN_ENC_DOUBLE, FN_ENC_QUAD, FN_PULSE_GATE})
          func_eff[i] = FN_OFF; // [RULE5]
      end
    end
  end

  // Four counter channels, second input is the neighbouring pin
  genvar g;
  generate
    for (g = 0; g < NCNT; g++)
    begin : g_ch
      counter_channel #(
        .CW (CW)
      ) u_ch (
        .clk_i      (CLOCK_I),
        .rst_n_i    (RST_N_I),
        .a_i        (din_s2_q[g]),
        .b_i        (din_s2_q[g ^ 1]),
        .func_i     (func_eff[g]),
        .dir_down_i (dir_down[g]),
        .periodic_i (periodic[g]),
        .limit_i    (limit_q[g]),
        .preset_i   (preset_q[g]),
        .load_i     (load_q[g]),
        .count_o    (count[g]),
        .hit_o      (hit[g])
      ); // [RULE3]
    end
  endgenerate

  // Per-channel configuration fields
  always_comb
  begin
    for (int i = 0; i < NCNT; i++)
    begin
      dir_down[i] = ctrl_q[i][`CTRL_DIR_BIT];
      periodic[i] = ctrl_q[i][`CTRL_PERIODIC_BIT];
      alm_en[i]   = ctrl_q[i][`CTRL_ALM_EN_BIT];
      diag_sel[i] = ctrl_q[i][`CTRL_ALM_DIAG_BIT];
    end
  end

  // Limit events gated by the alarm enable
  always_comb
  begin
    alm_ev = hit & alm_en; // [RULE10]
  end

  // Pending alarm flags, write one to clear, new event wins
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      alarm_q <= '0;
    else if (wr_clear)
      alarm_q <= (alarm_q & ~HWDATA_I[NCNT-1:0]) | alm_ev;
    else
      alarm_q <= alarm_q | alm_ev;
  end

  // Process alarm pulse on every enabled limit hit
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      PROC_ALARM_O <= '0;
    else
      PROC_ALARM_O <= alm_ev; // [RULE11]
  end

  // Diagnostics pulse when a hit finds the previous alarm still pending
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      DIAG_ALARM_O <= '0;
    else
      DIAG_ALARM_O <= alm_ev & alarm_q & diag_sel; // [RULE11]
  end

  // Process image of all counters, one cycle behind the counters
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      COUNT_IMAGE_O <= '0;
    else
    begin
      for (int i = 0; i < NCNT; i++)
        COUNT_IMAGE_O[i*CW +: CW] <= count[i]; // [RULE1]
    end
  end

  // Published start address of the image
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      IMAGE_BASE_O <= `IMG_BASE_RST;
    else
      IMAGE_BASE_O <= img_base_q; // [RULE1]
  end
endmodule

//--- fast_input_counter_tb.sv
// Self-checking bench for the fast counter block
`timescale 1ns/1ps
`include "fic_defs.svh"
module fast_input_counter_tb
  import fic_pkg::*;
;
  bit           clk;
  logic         rst_n;
  logic         hsel;
  logic [7:0]   haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hready;
  logic [3:0]   din;
  logic [127:0] img;
  logic [9:0]   base;
  logic [3:0]   palm;
  logic [3:0]   dalm;
  int           n_errors;
  int           samples_checked;
  int           n_hit;
  int           n_diag;
  logic [31:0]  r;
  always #2 clk = ~clk;
  always @(posedge clk) n_hit += palm[0];
  always @(posedge clk) n_diag += dalm[0];
  fast_input_counter DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
    .DIN_I(din), .COUNT_IMAGE_O(img), .IMAGE_BASE_O(base), .PROC_ALARM_O(palm),
    .DIAG_ALARM_O(dalm));
  fic_src src (.clk_i(clk), .din_o(din));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      n_errors++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic zero(input int i);
    wr(8'h20 + 8'(4 * i), 32'h0);
    wr(`OFS_LOAD, 32'h1 << i);
  endtask
  task automatic pul(input logic [3:0] m);
    src.put(din | m);
    src.put(din & ~m);
  endtask
  function automatic logic [31:0] cnt(input int i);
    return img[32 * i +: 32];
  endfunction
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    chk("base", 32'(base), 32'd136);
    wr(8'h00, 32'(FN_OFF));
    pul(4'hF);
    settle();
    chk("idle", cnt(0) | cnt(3), 32'h0);
    xfer(1'b0, 8'hFC, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask
  task automatic t_base();
    wr(`OFS_IMG_BASE, 32'd1008);
    settle();
    chk("base max", 32'(base), 32'd1008);
    wr(`OFS_IMG_BASE, 32'd1009);
    settle();
    chk("base kept", 32'(base), 32'd1008);
    wr(`OFS_IMG_BASE, 32'd136);
  endtask
  task automatic t_pulse();
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'(FN_PULSE) | ((i % 2) ? 32'h10 : 32'h0));
    pul(4'hF);
    pul(4'hF);
    settle();
    chk("up", cnt(2), 32'h2);
    chk("down wrap", cnt(3), 32'hFFFF_FFFE);
    xfer(1'b0, 8'h44, 32'h0);
    chk("count read", r, 32'hFFFF_FFFE);
    wr(8'h20, 32'hFFFF_FFFF);
    wr(`OFS_LOAD, 32'h1);
    settle();
    chk("preset", cnt(0), 32'hFFFF_FFFF);
    pul(4'h1);
    settle();
    chk("up wrap", cnt(0), 32'h0);
  endtask
  task automatic t_dir();
    logic [31:0] e;
    e = 32'h0;
    for (int d = 0; d < 2; d++)
    begin
      wr(8'h00, 32'(FN_PULSE_DIR) | (d ? 32'h10 : 32'h0));
      for (int b = 0; b < 2; b++)
      begin
        src.put(b ? 4'h2 : 4'h0);
        pul(4'h1);
        e = (b != d) ? e - 32'h1 : e + 32'h1;
        settle();
        chk("direction", cnt(0), e);
      end
    end
    chk("pair off", cnt(1), 32'hFFFF_FFFE);
  endtask
  task automatic t_gate();
    wr(8'h08, 32'(FN_PULSE_GATE));
    zero(2);
    pul(4'h4);
    src.put(4'h8);
    pul(4'h4);
    settle();
    chk("gate", cnt(2), 32'h1);
    src.put(4'h0);
  endtask
  task automatic t_enc();
    cnt_func_t f[3] = '{FN_ENC_QUAD, FN_ENC_DOUBLE, FN_ENC_SINGLE};
    for (int m = 0; m < 3; m++)
    begin
      wr(8'h00, 32'(f[m]));
      zero(0);
      src.put(4'h1);
      src.put(4'h3);
      src.put(4'h2);
      src.put(4'h0);
      settle();
      chk("enc fwd", cnt(0), 32'(4 >> m));
      src.put(4'h2);
      src.put(4'h3);
      src.put(4'h1);
      src.put(4'h0);
      settle();
      chk("enc rev", cnt(0), 32'h0);
    end
  endtask
  task automatic t_limit();
    int h0;
    int d0;
    zero(0);
    wr(8'h10, 32'h3);
    wr(8'h00, 32'(FN_PULSE) | 32'hE0);
    h0 = n_hit;
    d0 = n_diag;
    repeat (3) pul(4'h1);
    settle();
    chk("reload", cnt(0), 32'h0);
    xfer(1'b0, `OFS_ALARM, 32'h0);
    chk("pending", r, 32'h1);
    repeat (3) pul(4'h1);
    settle();
    chk("hits", 32'(n_hit - h0), 32'h2);
    chk("diag", 32'(n_diag - d0), 32'h1);
    wr(`OFS_ALARM, 32'h1);
    xfer(1'b0, `OFS_ALARM, 32'h0);
    chk("cleared", r, 32'h0);
    wr(8'h00, 32'(FN_PULSE) | 32'h40);
    repeat (4) pul(4'h1);
    settle();
    chk("continuous", cnt(0), 32'h4);
    chk("no hit", 32'(n_hit - h0), 32'h2);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    n_errors++;
    summarize();
  end
  initial
  begin
    rst_n  <= 1'b0;
    hsel   <= 1'b0;
    haddr  <= 8'h00;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize  <= 3'h2;
    hwdata <= 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    t_reset();
    t_base();
    t_pulse();
    t_dir();
    t_gate();
    t_enc();
    t_limit();
    summarize();
  end
endmodule

//--- fic_defs.svh
// Register offsets, field positions and reset values of the fast counter block
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH
`define GRP_CTRL          4'h0
`define GRP_LIMIT         4'h1
`define GRP_PRESET        4'h2
`define GRP_MISC          4'h3
`define GRP_COUNT         4'h4
`define OFS_IMG_BASE      8'h30
`define OFS_LOAD          8'h34
`define OFS_ALARM         8'h38
`define CTRL_FUNC_LSB     0
`define CTRL_FUNC_W       3
`define CTRL_DIR_BIT      4
`define CTRL_PERIODIC_BIT 5
`define CTRL_ALM_EN_BIT   6
`define CTRL_ALM_DIAG_BIT 7
`define CTRL_RST          8'h00
`define LIMIT_RST         32'h0000_0000
`define PRESET_RST        32'h0000_0000
`define COUNT_RST         32'h0000_0000
`define IMG_BASE_RST      10'h088
`define IMG_BASE_MAX      10'h3F0
`define IMG_BYTES         16
`define MAX_RATE_KHZ      30
`endif

//--- fic_pkg.sv
// Types shared by the fast counter block
package fic_pkg;
  typedef enum logic [2:0] {
    FN_OFF,
    FN_PULSE,
    FN_PULSE_DIR,
    FN_ENC_SINGLE,
    FN_ENC_DOUBLE,
    FN_ENC_QUAD,
    FN_PULSE_GATE
  } cnt_func_t;
endpackage

//--- fic_src.sv
// Pulse source and encoder model driving the counter inputs
`timescale 1ns/1ps
module fic_src
(
  input  wire logic       clk_i,
  output logic      [3:0] din_o
);
  initial din_o = 4'h0;
  // Each level holds 5 cycles, above the 3-cycle minimum
  // No input delay on any line, so all four are equal
  task automatic put(input logic [3:0] v);
    @(posedge clk_i);
    din_o <= v;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

//--- fic_sva.sv
// Port assertions for the fast counter block
`timescale 1ns/1ps
`include "fic_defs.svh"
module fic_sva
  import fic_pkg::*;
#(
  parameter int NCNT = 4,
  parameter int CW   = 32,
  parameter int AW   = 8
)
(
  input wire logic               CLOCK_I,
  input wire logic               RST_N_I,
  input wire logic               HSEL_I,
  input wire logic [AW-1:0]      HADDR_I,
  input wire logic [1:0]         HTRANS_I,
  input wire logic               HWRITE_I,
  input wire logic [2:0]         HSIZE_I,
  input wire logic [31:0]        HWDATA_I,
  input wire logic               HREADY_I,
  input wire logic [31:0]        HRDATA_O,
  input wire logic               HREADYOUT_O,
  input wire logic               HRESP_O,
  input wire logic [NCNT-1:0]    DIN_I,
  input wire logic [NCNT*CW-1:0] COUNT_IMAGE_O,
  input wire logic [9:0]         IMAGE_BASE_O,
  input wire logic [NCNT-1:0]    PROC_ALARM_O,
  input wire logic [NCNT-1:0]    DIAG_ALARM_O
);
  logic       cfg_q;
  logic       alm_q;
  logic [3:0] since_q;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // Write seen, alarm seen, cycles since an input moved
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      cfg_q   <= 1'b0;
      alm_q   <= 1'b0;
      since_q <= 4'h0;
    end
    else
    begin
      cfg_q   <= cfg_q | (HSEL_I & HTRANS_I[1] & HWRITE_I);
      alm_q   <= alm_q | (|PROC_ALARM_O);
      since_q <= (DIN_I != $past(DIN_I)) ? 4'h0 : since_q + 4'(since_q != 4'hF);
    end
  end
  property p_base_max;
    IMAGE_BASE_O <= `IMG_BASE_MAX;
  endproperty
  a_base_max: assert property (p_base_max) else $error("image base out of range");
  property p_base_rst;
    !cfg_q |-> IMAGE_BASE_O == `IMG_BASE_RST;
  endproperty
  a_base_rst: assert property (p_base_rst) else $error("image base default wrong");
  property p_idle;
    !cfg_q |-> COUNT_IMAGE_O == '0 && PROC_ALARM_O == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("counting before setup");
  property p_still;
    (!HSEL_I && $stable(DIN_I)) [*6] |-> $stable(COUNT_IMAGE_O);
  endproperty
  a_still: assert property (p_still) else $error("count moved without input");
  property p_pulse;
    |PROC_ALARM_O |=> PROC_ALARM_O == '0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("alarm longer than one cycle");
  property p_diag;
    (DIAG_ALARM_O & ~PROC_ALARM_O) == '0;
  endproperty
  a_diag: assert property (p_diag) else $error("diag alarm alone");
  property p_diag_after;
    |DIAG_ALARM_O |-> alm_q;
  endproperty
  a_diag_after: assert property (p_diag_after) else $error("diag on first hit");
  property p_hit;
    |PROC_ALARM_O |-> since_q >= 4'h1 && since_q <= 4'h8;
  endproperty
  a_hit: assert property (p_hit) else $error("hit without input change");
endmodule
bind fast_input_counter fic_sva #(.NCNT(NCNT), .CW(CW), .AW(AW)) u_sva (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
  .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .DIN_I(DIN_I), .COUNT_IMAGE_O(COUNT_IMAGE_O),
  .IMAGE_BASE_O(IMAGE_BASE_O), .PROC_ALARM_O(PROC_ALARM_O), .DIAG_ALARM_O(DIAG_ALARM_O));
